//--- core/mcd_pkg.sv
// Shared constants and carrier types for the modem change detector.
// Assumes one clock domain and an 8-bit register port.
package mcd_pkg;

	// Register addresses on the plain register port
	localparam logic [7:0] ADDR_OPT1  = 8'h15;  // Fall enables and hold-off threshold
	localparam logic [7:0] ADDR_OPT2  = 8'h16;  // Rise enables
	localparam logic [7:0] ADDR_SIG1  = 8'h6c;  // Modem levels plus request-to-send
	localparam logic [7:0] ADDR_SIG2  = 8'h6d;  // Modem levels plus terminal ready
	localparam logic [7:0] ADDR_ISTAT = 8'h70;  // Sticky change flags, write one to clear
	localparam logic [7:0] ADDR_IMASK = 8'h71;  // Interrupt mask, same layout

	// Field positions
	localparam int EDGE_LSB     = 4;  // Per-pin bits live in [7:4]
	localparam int EDGE_MSB     = 7;
	localparam int THR_MSB      = 3;  // Threshold lives in [3:0]
	localparam int SIG1_RTS_BIT = 0;
	localparam int SIG2_DTR_BIT = 1;

	// Reset values and codes
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [3:0] THR_OFF   = 4'h0;  // Automatic hold-off disabled
	localparam logic [3:0] PIN_IDLE  = 4'hf;  // Inactive level of active-low pins

	// Synchroniser depth for pin inputs
	localparam int SYNC_STAGES = 2;

	// One register-port request
	typedef struct packed {
		logic [7:0] addr;   // Register address
		logic [7:0] wdata;  // Write data
		logic       wr;     // Write strobe
		logic       rd;     // Read strobe
	} mcd_bus_s;

endpackage

//--- core/mcd_sync.sv
// Two-stage synchroniser, one chain per bit, for asynchronous pins.
// Assumes an active-low reset already synchronous to clk_i.
`timescale 1ns/10ps
module mcd_sync #(
	parameter int         W       = 4,
	parameter logic [3:0] RST_VAL = 4'hf
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_ni,
	// Data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	// Check width against the reset constant
	generate
		if (W > 4)
		begin : g_chk
			$error("mcd_sync: W above 4 not supported");
		end
	endgenerate

	// One chain per bit; first stage feeds only the second
	genvar b;
	generate
		for (b = 0; b < W; b++)
		begin : g_bit
			logic meta_q;  // First stage, read by the second only
			always_ff @(posedge clk_i or negedge rst_ni)
			begin
				if (!rst_ni)
				begin
					meta_q <= RST_VAL[b];
					q_o[b] <= RST_VAL[b];
				end
				else
				begin
					meta_q <= d_i[b];
					q_o[b] <= meta_q;
				end
			end
		end
	endgenerate

endmodule

//--- core/mcd_top.sv
// Modem-input change detection and automatic terminal-ready hold-off.
// Assumes receive occupancy comes from logic on clk_i; modem pins are async.
`timescale 1ns/10ps

// Overview of operation
// - Option-one high nibble enables falling-change requests
// - Rise, fall or both selectable per input
// - Occupancy above threshold negates terminal ready
// - Threshold zero disables automatic hold-off
// - Codes one to twelve count characters
// - Option-two high nibble enables rising-change requests
// - Modem pins inverted relative to register bits
module mcd_top #(
	parameter int unsigned RX_DEPTH = 12  // Largest meaningful threshold code
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             nrst_i,
	// Register port
	input  wire mcd_pkg::mcd_bus_s bus_i,
	output logic      [7:0]       rdata_o,
	// Modem pins, active low: [3] set ready, [2] clear to send, [1] ring, [0] carrier
	input  wire logic [3:0]       modem_n_i,
	output logic                  dtr_n_o,
	output logic                  rts_n_o,
	// Receive side
	input  wire logic [3:0]       rx_count_i,
	// Service request
	output logic                  irq_o,
	output logic                  modem_service_request_n_o
);

	// Threshold codes must fit the four-bit field
	generate
		if (RX_DEPTH < 1 || RX_DEPTH > 15)
		begin : g_chk
			$error("mcd_top: RX_DEPTH must be 1..15");
		end
	endgenerate

	localparam logic [3:0] THR_TOP = 4'(RX_DEPTH);  // Highest defined code

	// Reset release through two flops
	logic [1:0] rst_q;  // Release shift
	logic       rst_n;  // Design-wide reset
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			rst_q <= 2'h0;
		else
			rst_q <= {rst_q[0], 1'b1};
	end
	assign rst_n = rst_q[1];

	// Pin synchronisation
	logic [3:0] pin_n_s;  // Synchronised pin levels
	logic [3:0] lvl;      // Status-bit sense of the pins
	mcd_sync #(
		.W       (4),
		.RST_VAL (mcd_pkg::PIN_IDLE)
	) u_sync (
		.clk_i  (clk_i),
		.rst_ni (rst_n),
		.d_i    (modem_n_i),
		.q_o    (pin_n_s)
	);
	assign lvl = ~pin_n_s;

	// Register state
	logic [7:0] opt1_q, opt1_d;    // Fall enables, threshold
	logic [7:0] opt2_q, opt2_d;    // Rise enables
	logic [7:0] stat_q, stat_d;    // Sticky change flags
	logic [7:0] mask_q, mask_d;    // Interrupt mask
	logic       rts_q, rts_d;      // Request-to-send control bit
	logic       dtr_q, dtr_d;      // Terminal-ready control bit
	logic [3:0] lvl_q, lvl_d;      // Previous level for edge compare
	logic [7:0] rdata_q, rdata_d;  // Read data, valid one cycle
	logic       irq_q, irq_d;      // Interrupt level
	logic       dtr_n_q, dtr_n_d;  // Pin drive
	logic       rts_n_q, rts_n_d;
	logic       srq_n_q, srq_n_d;  // Service request pin, own flop so no gate sits on it

	// Decode and detection terms
	logic [3:0] fall, rise;  // Enabled edges this cycle
	logic [3:0] thr;         // Hold-off threshold
	logic       auto_on;     // Automatic mode armed
	logic       hold;        // Occupancy over threshold
	logic [7:0] clr;         // Write-one-to-clear mask

	// Next-state logic for every register
	always_comb
	begin
		// Edge detection against the last level
		fall = lvl_q & ~lvl & opt1_q[mcd_pkg::EDGE_MSB:mcd_pkg::EDGE_LSB];
		rise = ~lvl_q & lvl & opt2_q[mcd_pkg::EDGE_MSB:mcd_pkg::EDGE_LSB];
		thr = opt1_q[mcd_pkg::THR_MSB:0];
		// Undefined codes are treated as off so a bad setting cannot stall the far end
		auto_on = (thr != mcd_pkg::THR_OFF) && (thr <= THR_TOP);
		hold = auto_on && (rx_count_i > thr);
		clr = 8'h00;
		opt1_d = opt1_q;
		opt2_d = opt2_q;
		mask_d = mask_q;
		rts_d = rts_q;
		dtr_d = dtr_q;
		rdata_d = 8'h00;
		// Register writes
		if (bus_i.wr)
		begin
			case (bus_i.addr)
				mcd_pkg::ADDR_OPT1:  opt1_d = bus_i.wdata;
				mcd_pkg::ADDR_OPT2:  opt2_d = {bus_i.wdata[7:4], 4'h0};  // Low bits unused
				mcd_pkg::ADDR_SIG1:  rts_d = bus_i.wdata[mcd_pkg::SIG1_RTS_BIT];
				mcd_pkg::ADDR_SIG2:  dtr_d = bus_i.wdata[mcd_pkg::SIG2_DTR_BIT];
				mcd_pkg::ADDR_ISTAT: clr = bus_i.wdata;
				mcd_pkg::ADDR_IMASK: mask_d = {bus_i.wdata[7:4], 4'h0};
				default:             clr = 8'h00;  // Unmapped writes ignored
			endcase
		end
		// Register reads; unmapped reads return zero
		if (bus_i.rd)
		begin
			case (bus_i.addr)
				mcd_pkg::ADDR_OPT1:  rdata_d = opt1_q;
				mcd_pkg::ADDR_OPT2:  rdata_d = opt2_q;
				mcd_pkg::ADDR_SIG1:  rdata_d = {lvl, 3'h0, rts_q};
				mcd_pkg::ADDR_SIG2:  rdata_d = {lvl, 2'h0, dtr_q, 1'b0};
				mcd_pkg::ADDR_ISTAT: rdata_d = stat_q;
				mcd_pkg::ADDR_IMASK: rdata_d = mask_q;
				default:             rdata_d = 8'h00;
			endcase
		end
		// Set wins over a same-cycle clear
		stat_d = (stat_q & ~clr) | {fall | rise, 4'h0};
		lvl_d = lvl;
		irq_d = |(stat_q & mask_q);
		srq_n_d = ~irq_d;  // Same cycle as the interrupt level, opposite sense
		// Pins are the inverse of the bits; hold-off overrides the control bit
		dtr_n_d = ~(dtr_q & ~hold);
		rts_n_d = ~rts_q;
	end

	// Registers
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			opt1_q  <= mcd_pkg::REG_RESET;
			opt2_q  <= mcd_pkg::REG_RESET;
			stat_q  <= mcd_pkg::REG_RESET;
			mask_q  <= mcd_pkg::REG_RESET;
			rts_q   <= 1'b0;
			dtr_q   <= 1'b0;
			lvl_q   <= 4'h0;
			rdata_q <= 8'h00;
			irq_q   <= 1'b0;
			dtr_n_q <= 1'b1;
			rts_n_q <= 1'b1;
			srq_n_q <= 1'b1;
		end
		else
		begin
			opt1_q  <= opt1_d;
			opt2_q  <= opt2_d;
			stat_q  <= stat_d;
			mask_q  <= mask_d;
			rts_q   <= rts_d;
			dtr_q   <= dtr_d;
			lvl_q   <= lvl_d;
			rdata_q <= rdata_d;
			irq_q   <= irq_d;
			dtr_n_q <= dtr_n_d;
			rts_n_q <= rts_n_d;
			srq_n_q <= srq_n_d;
		end
	end

	// Outputs straight from flops
	assign rdata_o = rdata_q;
	assign irq_o = irq_q;
	// Service request has its own register rather than an inverter after irq_q
	assign modem_service_request_n_o = srq_n_q;
	assign dtr_n_o = dtr_n_q;
	assign rts_n_o = rts_n_q;

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n);

	// Enabled edge, then flag visible next cycle
	sequence fall_seen;
		|fall;
	endsequence
	sequence rise_seen;
		|rise;
	endsequence

	fall_flag_a: assert property (fall_seen |=> ((stat_q[7:4] & $past(fall)) == $past(fall)))
		else $error("falling change not flagged");
	rise_flag_a: assert property (rise_seen |=> ((stat_q[7:4] & $past(rise)) == $past(rise)))
		else $error("rising change not flagged");
	flag_cause_a: assert property (((stat_q[7:4] & ~$past(stat_q[7:4]))
		& ~$past(fall | rise)) == 4'h0)
		else $error("change flag set without enabled edge");
	hold_off_a: assert property ((hold && dtr_q) |=> dtr_n_o)
		else $error("terminal ready not negated over threshold");
	auto_off_a: assert property ((thr == mcd_pkg::THR_OFF) |=> (dtr_n_o == !$past(dtr_q)))
		else $error("threshold zero still affects terminal ready");
	code_range_a: assert property ((thr > THR_TOP) |=> (dtr_n_o == !$past(dtr_q)))
		else $error("unused threshold code affects terminal ready");
	reassert_a: assert property ((auto_on && dtr_q && rx_count_i <= thr) |=> !dtr_n_o)
		else $error("terminal ready not reasserted at threshold");
	pin_sense_a: assert property (($stable(modem_n_i))[*4] |-> (lvl_q == ~modem_n_i))
		else $error("modem level not inverse of pin");
	irq_level_a: assert property ((|(stat_q & mask_q)) |=> (irq_o && !modem_service_request_n_o))
		else $error("unmasked flag without interrupt");
	srq_quiet_a: assert property (!(|(stat_q & mask_q)) |=> (!irq_o && modem_service_request_n_o))
		else $error("service request without unmasked flag");

endmodule

//--- verification/mcd_modem_model.sv
// Behavioural modem facing the channel's modem pins.
// Assumes the bench calls drive() to change the modem's output levels.
`timescale 1ns/10ps
module mcd_modem_model (
	// Clock
	input  wire logic       clk_i,
	// Channel outputs seen by the modem, active low
	input  wire logic       dtr_n_i,
	input  wire logic       rts_n_i,
	// Modem outputs, active low
	output logic      [3:0] modem_n_o
);
	// Pins start inactive, which is high on these active-low lines
	logic [3:0] pins_q = mcd_pkg::PIN_IDLE;

	// Change just after an edge; the level holds until the next call
	task automatic drive(input logic [3:0] v);
		@(posedge clk_i);
		pins_q <= v;
	endtask

	// Levels go straight onto the wire
	assign modem_n_o = pins_q;

	// What the modem last saw on the channel's outputs, sampled each edge
	logic [1:0] seen_n_q;  // {terminal ready, request to send}, active low
	always_ff @(posedge clk_i)
	begin
		seen_n_q <= {dtr_n_i, rts_n_i};
	end
endmodule

//--- verification/tb_mcd_top.sv
// Self-checking bench for the modem change detector.
// Assumes a 25 MHz clock and the register map of mcd_pkg.
`timescale 1ns/10ps
module tb_mcd_top;
	logic              clk = 1'b0;     // 40 ns clock
	logic              nrst = 1'b0;    // Async reset, active low
	mcd_pkg::mcd_bus_s bus = '0;       // Register request
	logic        [7:0] rdata;          // Read data
	logic        [3:0] pins;           // Modem pins
	logic        [3:0] rx_cnt = 4'h0;  // Receive occupancy
	logic              dtr_n;          // Terminal ready pin
	logic              rts_n;          // Request to send pin
	logic              irq;            // Interrupt
	logic              srq_n;          // Service request, active low
	int                n_errors = 0;
	int                checks_done = 0;

	// Free-running clock
	initial
	begin
		forever #20 clk = ~clk;
	end

	mcd_top dut (
		.clk_i(clk), .nrst_i(nrst), .bus_i(bus), .rdata_o(rdata),
		.modem_n_i(pins), .dtr_n_o(dtr_n), .rts_n_o(rts_n),
		.rx_count_i(rx_cnt), .irq_o(irq), .modem_service_request_n_o(srq_n)
	);
	mcd_modem_model modem (.clk_i(clk), .dtr_n_i(dtr_n), .rts_n_i(rts_n), .modem_n_o(pins));

	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One-cycle write; strobe drops at the taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask

	// One-cycle read; data stands only in the following cycle
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 chk(rdata, exp);
	endtask

	// Let edges pass, then settle
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Threshold and occupancy against the terminal-ready pin
	task automatic dtr_case(input logic [3:0] thr, input logic [3:0] cnt, input logic exp);
		wr(mcd_pkg::ADDR_OPT1, {4'h0, thr});
		@(posedge clk);
		rx_cnt <= cnt;
		idle(2);
		chk({7'h00, dtr_n}, {7'h00, exp});
	endtask

	// Verdict and end of run
	task automatic conclude();
		if (n_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Hang guard, far beyond the roughly 135 cycles of the tests
	initial
	begin
		repeat (4000) @(posedge clk);
		n_errors++;
		conclude();
	end

	// Main sequence
	initial
	begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		idle(3);
		rd(mcd_pkg::ADDR_OPT1, 8'h00);
		chk({6'h00, dtr_n, rts_n}, 8'h03);
		chk({6'h00, modem.seen_n_q}, 8'h03);
		modem.drive(4'h5);
		idle(6);
		rd(mcd_pkg::ADDR_SIG1, 8'ha0);
		modem.drive(4'hf);
		wr(mcd_pkg::ADDR_IMASK, 8'hf0);
		wr(mcd_pkg::ADDR_OPT1, 8'h80);
		idle(6);
		wr(mcd_pkg::ADDR_ISTAT, 8'hf0);
		// Rising level on a fall-only pin stays quiet
		modem.drive(4'h7);
		idle(8);
		rd(mcd_pkg::ADDR_ISTAT, 8'h00);
		modem.drive(4'hf);
		idle(8);
		rd(mcd_pkg::ADDR_ISTAT, 8'h80);
		chk({6'h00, irq, srq_n}, 8'h02);
		wr(mcd_pkg::ADDR_ISTAT, 8'h80);
		idle(2);
		chk({6'h00, irq, srq_n}, 8'h01);
		// Both senses on clear to send
		wr(mcd_pkg::ADDR_OPT2, 8'h40);
		wr(mcd_pkg::ADDR_OPT1, 8'h40);
		modem.drive(4'hb);
		idle(8);
		rd(mcd_pkg::ADDR_ISTAT, 8'h40);
		wr(mcd_pkg::ADDR_ISTAT, 8'h40);
		wr(mcd_pkg::ADDR_IMASK, 8'h00);
		modem.drive(4'hf);
		idle(8);
		rd(mcd_pkg::ADDR_ISTAT, 8'h40);
		chk({7'h00, irq}, 8'h00);
		wr(mcd_pkg::ADDR_ISTAT, 8'h40);
		// Output pins follow their bits inverted, as the modem sees them
		wr(mcd_pkg::ADDR_SIG2, 8'h02);
		wr(mcd_pkg::ADDR_SIG1, 8'h01);
		idle(2);
		chk({6'h00, dtr_n, rts_n}, 8'h00);
		chk({6'h00, modem.seen_n_q}, 8'h00);
		// Thresholds 3 and 12 checked one above and at the code; zero ignores occupancy
		dtr_case(4'h3, 4'h4, 1'b1);
		dtr_case(4'h3, 4'h3, 1'b0);
		dtr_case(4'h0, 4'hf, 1'b0);
		dtr_case(4'hc, 4'hd, 1'b1);
		dtr_case(4'hc, 4'hc, 1'b0);
		// Unused codes leave terminal ready to its control bit
		dtr_case(4'hd, 4'hf, 1'b0);
		// Reset in mid-run brings option one back to zero and both output pins high
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		idle(3);
		rd(mcd_pkg::ADDR_OPT1, 8'h00);
		chk({6'h00, dtr_n, rts_n}, 8'h03);
		conclude();
	end
endmodule
